/* File: rtl/pcmd_pkg.sv */
`default_nettype none
package pcmd_pkg;
	// Sampling clock rate
	localparam int CLK_MHZ = 100;
	// Switch protection times
	localparam int SHORT_NS = 850;
	localparam int SHORT_CYC = SHORT_NS * CLK_MHZ / 1000;
	localparam int BLANK_NS = 200;
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int MAXON_US = 50;
	localparam int MAXON_CYC = MAXON_US * CLK_MHZ;
	// Pulse line glitch rejection
	localparam int GLITCH_US = 4;
	localparam int GLITCH_CYC = GLITCH_US * CLK_MHZ;
	// Decode window, accurate range and default length
	localparam int WIN_MIN_US = 1900;
	localparam int WIN_MAX_US = 31000;
	localparam int WIN_DEF_CYC = WIN_MIN_US * CLK_MHZ;
	// Edge counter
	localparam int CNT_W = 3;
	localparam logic [2:0] CNT_SAT = 3'h5;
	localparam logic [2:0] CNT_LAST_OK = 3'h4;
	// Register byte addresses
	localparam logic [3:0] ADDR_WINLEN = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	// Status field positions
	localparam int ST_CNT_LSB = 0;
	localparam int ST_COMM_FLT = 4;
	localparam int ST_SW_ERR = 5;
	localparam int ST_UVLO = 6;
	localparam int ST_WIN = 7;
	localparam int ST_RUN = 8;
	localparam int ST_SERIAL = 9;
	localparam int ST_SW_EN = 10;
	localparam int ST_LVL_LSB = 12;
	// Output level codes for the analog stage
	typedef enum logic [3:0] {
		LVL_CELL, LVL_SENSE, LVL_TEMP, LVL_FAULT, LVL_SWERR,
		LVL_HS1, LVL_HS2, LVL_HS3, LVL_HS4
	} pcmd_level_t;
	// Serial sequencer states
	typedef enum logic [1:0] {ST_OFF, ST_WINDOW, ST_ACTIVE} pcmd_state_t;
endpackage
`default_nettype wire

/* File: rtl/pcmd_decoder.sv */
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pcmd_decoder
	import pcmd_pkg::*;
#(
	parameter int MAXON_CYCLES = MAXON_CYC,
	parameter int WIN_DEF_CYCLES = WIN_DEF_CYC
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pulse_n_pin,
	input wire logic mode_pin,
	input wire logic discharge_enable_io_i,
	output logic discharge_enable_io_o,
	output logic discharge_enable_io_oe,
	input wire logic switch_on,
	input wire logic current_trip,
	input wire logic clamp_active,
	input wire logic uvlo,
	output logic switch_en,
	output logic window_timer_pin,
	output logic power_latch,
	output var pcmd_level_t out_level
);
	// Handshake level for a running count
	function automatic pcmd_level_t hs_level(input logic [2:0] c);
		case (c)
			3'h1: hs_level = LVL_HS1;
			3'h2: hs_level = LVL_HS2;
			3'h3: hs_level = LVL_HS3;
			3'h4: hs_level = LVL_HS4;
			default: hs_level = LVL_FAULT;
		endcase
	endfunction

	// Measurement selected by a final count
	function automatic pcmd_level_t mode_level(input logic [2:0] c);
		case (c)
			3'h1: mode_level = LVL_CELL;
			3'h2: mode_level = LVL_SENSE;
			3'h3, 3'h4: mode_level = LVL_TEMP;
			default: mode_level = LVL_FAULT;
		endcase
	endfunction

	logic [1:0] pulse_sy_q, mode_sy_q, discharge_enable_io_sy_q, on_sy_q, trip_sy_q, clamp_sy_q, uvlo_sy_q;
	logic pulse_f_q, pulse_prev_q;
	logic [8:0] gl_cnt_q;
	logic [15:0] on_cnt_q;
	logic [4:0] clamp_cnt_q;
	logic [31:0] win_cnt_q, win_len_q;
	logic [2:0] cnt_q;
	logic comm_fault_q, swerr_q, switch_en_q, timer_q, latch_q, discharge_enable_io_o_q, discharge_enable_io_oe_q, ack_q;
	logic [31:0] dat_q;
	pcmd_state_t state_q;
	pcmd_level_t level_q, level_d;
	logic serial, fall, win_end, swerr_set, en_d;

	// Two-stage synchronisers; only the second stage is read by logic
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pulse_sy_q <= 2'h3;
			mode_sy_q <= 2'h0;
			discharge_enable_io_sy_q <= 2'h0;
			on_sy_q <= 2'h0;
			trip_sy_q <= 2'h0;
			clamp_sy_q <= 2'h0;
			uvlo_sy_q <= 2'h0;
		end
		else
		begin
			pulse_sy_q <= {pulse_sy_q[0], pulse_n_pin};
			mode_sy_q <= {mode_sy_q[0], mode_pin};
			discharge_enable_io_sy_q <= {discharge_enable_io_sy_q[0], discharge_enable_io_i};
			on_sy_q <= {on_sy_q[0], switch_on};
			trip_sy_q <= {trip_sy_q[0], current_trip};
			clamp_sy_q <= {clamp_sy_q[0], clamp_active};
			uvlo_sy_q <= {uvlo_sy_q[0], uvlo};
		end
	end

	assign serial = ~mode_sy_q[1];
	assign fall = pulse_prev_q & ~pulse_f_q;

	// Glitch filter: a level must persist past the reject time to count
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pulse_f_q <= 1'b1;
			pulse_prev_q <= 1'b1;
			gl_cnt_q <= 9'h000;
		end
		else
		begin
			pulse_prev_q <= pulse_f_q;
			if (pulse_sy_q[1] == pulse_f_q)
				gl_cnt_q <= 9'h000;
			else if (gl_cnt_q == 9'(GLITCH_CYC))
			begin
				pulse_f_q <= pulse_sy_q[1];
				gl_cnt_q <= 9'h000;
			end
			else
				gl_cnt_q <= gl_cnt_q + 9'h001;
		end
	end

	// Switch on-time and clamp-time counters, saturating
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			on_cnt_q <= 16'h0000;
			clamp_cnt_q <= 5'h00;
		end
		else
		begin
			if (!on_sy_q[1])
				on_cnt_q <= 16'h0000;
			else if (on_cnt_q != 16'hFFFF)
				on_cnt_q <= on_cnt_q + 16'h0001;
			if (!clamp_sy_q[1])
				clamp_cnt_q <= 5'h00;
			else if (clamp_cnt_q != 5'h1F)
				clamp_cnt_q <= clamp_cnt_q + 5'h01;
		end
	end

	// Any protection trip; a short shows as a trip soon after turn-on
	assign swerr_set = (on_sy_q[1] && trip_sy_q[1] && on_cnt_q < 16'(SHORT_CYC))
		|| (on_cnt_q >= 16'(MAXON_CYCLES))
		|| (clamp_cnt_q > 5'(BLANK_CYC));

	// Switch error latch; in serial mode powering down is the part reset
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			swerr_q <= 1'b0;
		else if (swerr_set)
			swerr_q <= 1'b1;
		else if (serial && state_q == ST_OFF)
			swerr_q <= 1'b0;
	end

	assign win_end = state_q == ST_WINDOW && win_cnt_q >= win_len_q - 32'h1;

	// Serial sequencer: off, decode window, active
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ST_OFF;
			win_cnt_q <= 32'h0;
			cnt_q <= 3'h0;
		end
		else if (!serial)
			state_q <= ST_OFF;
		else
		begin
			case (state_q)
				ST_OFF:
				begin
					if (fall)
					begin
						state_q <= ST_WINDOW;
						win_cnt_q <= 32'h0;
						cnt_q <= 3'h0;
					end
				end
				ST_WINDOW:
				begin
					win_cnt_q <= win_cnt_q + 32'h1;
					if (fall && cnt_q != CNT_SAT)
						cnt_q <= cnt_q + 3'h1;
					if (win_end)
						state_q <= ST_ACTIVE;
				end
				ST_ACTIVE:
				begin
					if (pulse_f_q)
						state_q <= ST_OFF;
				end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	// Communication fault latch; set wins over the pulse-high clear
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			comm_fault_q <= 1'b0;
		else if (state_q == ST_WINDOW && fall && cnt_q == CNT_LAST_OK)
			comm_fault_q <= 1'b1;
		else if (state_q == ST_WINDOW && uvlo_sy_q[1])
			comm_fault_q <= 1'b1;
		else if (win_end && cnt_q == 3'h0 && !fall)
			comm_fault_q <= 1'b1;
		else if (state_q == ST_OFF && pulse_f_q)
			comm_fault_q <= 1'b0;
	end

	// Output level; undervoltage dominates, then switch error
	always_comb
	begin
		level_d = LVL_TEMP;
		if (uvlo_sy_q[1])
			level_d = LVL_FAULT;
		else if (swerr_q)
			level_d = LVL_SWERR;
		else if (serial)
		begin
			case (state_q)
				ST_OFF: level_d = LVL_CELL;
				ST_WINDOW: level_d = comm_fault_q ? LVL_FAULT : hs_level(cnt_q);
				ST_ACTIVE: level_d = comm_fault_q ? LVL_FAULT : mode_level(cnt_q);
				default: level_d = LVL_CELL;
			endcase
		end
	end

	// Switching enable; undervoltage and switch error block it in both modes
	always_comb
	begin
		en_d = 1'b0;
		if (!uvlo_sy_q[1] && !swerr_q)
		begin
			if (!serial)
				en_d = !pulse_f_q && discharge_enable_io_sy_q[1];
			else
				en_d = state_q == ST_ACTIVE && !comm_fault_q && cnt_q >= 3'h1 && cnt_q <= 3'h3;
		end
	end

	// Registered pin outputs
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			level_q <= LVL_CELL;
			switch_en_q <= 1'b0;
			timer_q <= 1'b0;
			latch_q <= 1'b0;
			discharge_enable_io_o_q <= 1'b0;
			discharge_enable_io_oe_q <= 1'b0;
		end
		else
		begin
			level_q <= level_d;
			switch_en_q <= en_d;
			timer_q <= serial && (state_q == ST_WINDOW || (state_q == ST_OFF && fall));
			latch_q <= serial && (state_q == ST_WINDOW ? !win_end : (state_q == ST_OFF && fall));
			discharge_enable_io_o_q <= serial && en_d;
			discharge_enable_io_oe_q <= serial;
		end
	end

	assign out_level = level_q;
	assign switch_en = switch_en_q;
	assign window_timer_pin = timer_q;
	assign power_latch = latch_q;
	assign discharge_enable_io_o = discharge_enable_io_o_q;
	assign discharge_enable_io_oe = discharge_enable_io_oe_q;

	// Wishbone slave: ack one cycle after the strobe, dropped the next
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
			win_len_q <= 32'(WIN_DEF_CYCLES);
		end
		else
		begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			dat_q <= 32'h0;
			if (wb_cyc_i && wb_stb_i && !ack_q)
			begin
				if (wb_we_i && wb_adr_i == ADDR_WINLEN)
				begin
					for (int b = 0; b < 4; b++)
						if (wb_sel_i[b])
							win_len_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
				else if (!wb_we_i && wb_adr_i == ADDR_WINLEN)
					dat_q <= win_len_q;
				else if (!wb_we_i && wb_adr_i == ADDR_STATUS)
				begin
					dat_q[ST_CNT_LSB +: 3] <= cnt_q;
					dat_q[ST_COMM_FLT] <= comm_fault_q;
					dat_q[ST_SW_ERR] <= swerr_q;
					dat_q[ST_UVLO] <= uvlo_sy_q[1];
					dat_q[ST_WIN] <= state_q == ST_WINDOW;
					dat_q[ST_RUN] <= state_q == ST_ACTIVE;
					dat_q[ST_SERIAL] <= serial;
					dat_q[ST_SW_EN] <= switch_en_q;
					dat_q[ST_LVL_LSB +: 4] <= level_q;
				end
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Checks
	property p_short;
		@(posedge sys_clk) disable iff (sys_rst)
		(on_sy_q[1] && trip_sy_q[1] && on_cnt_q < 16'(SHORT_CYC)) |=> swerr_q;
	endproperty
	a_short: assert property (p_short) else $error("early trip did not latch switch error");
	property p_swerr_off;
		@(posedge sys_clk) disable iff (sys_rst)
		swerr_q |=> !switch_en_q;
	endproperty
	a_swerr_off: assert property (p_swerr_off) else $error("switching with switch error");
	property p_uvlo;
		@(posedge sys_clk) disable iff (sys_rst)
		uvlo_sy_q[1] |=> (level_q == LVL_FAULT && !switch_en_q);
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("undervoltage not shown as fault");
	property p_count;
		@(posedge sys_clk) disable iff (sys_rst)
		(serial && state_q == ST_WINDOW && fall && cnt_q < CNT_SAT) |=> cnt_q == $past(cnt_q) + 3'h1;
	endproperty
	a_count: assert property (p_count) else $error("edge not counted");
	property p_freeze;
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == ST_ACTIVE) |=> $stable(cnt_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count changed after window");
	property p_over;
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == ST_WINDOW && cnt_q == CNT_SAT) |-> comm_fault_q;
	endproperty
	a_over: assert property (p_over) else $error("too many edges without fault");
	property p_winlen;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(window_timer_pin) && serial |-> $past(win_cnt_q) >= $past(win_len_q) - 32'h1;
	endproperty
	a_winlen: assert property (p_winlen) else $error("window ended early");
	property p_simple;
		@(posedge sys_clk) disable iff (sys_rst)
		(!serial && switch_en_q) |-> $past(!pulse_f_q && discharge_enable_io_sy_q[1]);
	endproperty
	a_simple: assert property (p_simple) else $error("simple mode enable wrong");
	property p_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		(serial && state_q == ST_ACTIVE && !pulse_f_q) |=> state_q == ST_ACTIVE;
	endproperty
	a_hold: assert property (p_hold) else $error("disabled while pulse line low");
	property p_discharge_enable_io;
		@(posedge sys_clk) disable iff (sys_rst)
		serial |=> (discharge_enable_io_oe && discharge_enable_io_o == switch_en_q);
	endproperty
	a_discharge_enable_io: assert property (p_discharge_enable_io) else $error("discharge pin not tracking enable");
endmodule
`default_nettype wire

/* File: test/pcmd_monitor_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Stack monitor side of the pulse line; idle level is high
module pcmd_monitor_model(
	input wire logic sys_clk,
	output logic pulse_n
);
	// Each level well beyond the glitch filter, so fall spacing stays over 8 us
	localparam int HALF = 600;
	initial pulse_n = 1'b1;
	task automatic lvl(input logic v, input int c);
		@(posedge sys_clk);
		pulse_n <= v;
		repeat (c - 1) @(posedge sys_clk);
	endtask
	// Opening fall, n counted falls, then the line stays low to keep the part active
	task automatic send(input int n);
		lvl(1'b0, HALF);
		repeat (n)
		begin
			lvl(1'b1, HALF);
			lvl(1'b0, HALF);
		end
	endtask
	// Raising the line shuts the part down and clears a latched fault
	task automatic rel();
		lvl(1'b1, HALF);
	endtask
	// Short low spike that must not open a window
	task automatic glitch();
		lvl(1'b0, 100);
		lvl(1'b1, HALF);
	endtask
endmodule
`default_nettype wire

/* File: test/pulse_count_mode_decoder_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pulse_count_mode_decoder_tb;
	import pcmd_pkg::*;
	localparam int WIN = 8000;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, pulse_n_pin, mode_pin = 1'b0, tb_dch = 1'b1;
	logic discharge_enable_io_o, discharge_enable_io_oe, switch_en, window_timer_pin, power_latch;
	logic switch_on = 1'b0, current_trip = 1'b0, clamp_active = 1'b0, uvlo = 1'b0;
	pcmd_level_t out_level;
	int miscompares = 0, n_compared = 0;
	// Wire level of the two-way pin from both drivers
	wire logic discharge_enable_io_i = discharge_enable_io_oe ? discharge_enable_io_o : tb_dch;
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end
	pcmd_decoder #(.MAXON_CYCLES(50), .WIN_DEF_CYCLES(WIN)) DUT (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pulse_n_pin, .mode_pin,
		.discharge_enable_io_i, .discharge_enable_io_o, .discharge_enable_io_oe, .switch_on, .current_trip,
		.clamp_active, .uvlo, .switch_en, .window_timer_pin, .power_latch, .out_level);
	pcmd_monitor_model mon (.sys_clk, .pulse_n(pulse_n_pin));
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chkw(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic chkl(input string nm, input pcmd_level_t e, input pcmd_level_t g);
		chkw(nm, {28'h0, e}, {28'h0, g});
	endtask
	task automatic timeout();
		miscompares++;
		$display("MISMATCH wait expected done seen timeout");
		end_of_test();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Outputs are looked at mid-cycle, clear of the edge updates
	task automatic settle(input int n);
		cyc(n);
		@(negedge sys_clk);
	endtask
	task automatic rst();
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		cyc(8);
		sys_rst <= 1'b0;
		cyc(4);
	endtask
	// Classic cycle; ack and read data are taken at the rising edge that samples ack high
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int i;
		i = 0;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1 && i < 50)
		begin
			@(posedge sys_clk);
			i++;
		end
		if (i == 50)
			timeout();
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wait_win();
		int i;
		for (i = 0; i < 2 * WIN && window_timer_pin !== 1'b0; i++)
			@(negedge sys_clk);
		if (i == 2 * WIN)
			timeout();
	endtask
	function automatic pcmd_level_t hs(input int n);
		return (n >= 1 && n <= 4) ? pcmd_level_t'(int'(LVL_HS1) + n - 1) : LVL_FAULT;
	endfunction
	function automatic pcmd_level_t md(input int n);
		case (n)
			1: return LVL_CELL;
			2: return LVL_SENSE;
			3, 4: return LVL_TEMP;
			default: return LVL_FAULT;
		endcase
	endfunction
	task automatic t_bus();
		logic [31:0] q;
		@(negedge sys_clk);
		chkl("out_level", LVL_CELL, out_level);
		chk1("timer", 1'b0, window_timer_pin);
		wb(1'b0, 4'h0, 32'h0, q);
		chkw("winlen", WIN, q);
		wb(1'b1, 4'h0, 32'h00002328, q);
		wb(1'b0, 4'h0, 32'h0, q);
		chkw("winlen", 32'h00002328, q);
		wb(1'b1, 4'h4, 32'hFFFFFFFF, q);
		wb(1'b0, 4'h4, 32'h0, q);
		chkw("status", 32'h00000200, q);
		wb(1'b0, 4'hC, 32'h0, q);
		chkw("unmapped", 32'h0, q);
		$display("test bus done");
	endtask
	// Every count from none to saturated, then undervoltage inside a window
	task automatic t_serial();
		for (int n = 0; n <= 5; n++)
		begin
			mon.send(n);
			@(negedge sys_clk);
			chk1("timer", 1'b1, window_timer_pin);
			chk1("latch", 1'b1, power_latch);
			chkl("handshake", hs(n), out_level);
			wait_win();
			chkl("mode", md(n), out_level);
			chk1("switch", n >= 1 && n <= 3, switch_en);
			chk1("dch", n >= 1 && n <= 3, discharge_enable_io_o);
			chk1("dch_oe", 1'b1, discharge_enable_io_oe);
			chk1("latch", 1'b0, power_latch);
			mon.rel();
			@(negedge sys_clk);
			chkl("off", LVL_CELL, out_level);
			chk1("switch", 1'b0, switch_en);
		end
		mon.send(1);
		uvlo <= 1'b1;
		cyc(10);
		uvlo <= 1'b0;
		wait_win();
		chkl("uvlo_win", LVL_FAULT, out_level);
		chk1("switch", 1'b0, switch_en);
		mon.rel();
		mon.glitch();
		@(negedge sys_clk);
		chk1("timer", 1'b0, window_timer_pin);
		chk1("latch", 1'b0, power_latch);
		$display("test serial done");
	endtask
	task automatic t_simple();
		@(posedge sys_clk);
		mode_pin <= 1'b1;
		rst();
		mon.lvl(1'b0, 600);
		@(negedge sys_clk);
		chk1("switch", 1'b1, switch_en);
		chkl("out", LVL_TEMP, out_level);
		chk1("dch_oe", 1'b0, discharge_enable_io_oe);
		@(posedge sys_clk);
		tb_dch <= 1'b0;
		settle(10);
		chk1("switch", 1'b0, switch_en);
		@(posedge sys_clk);
		tb_dch <= 1'b1;
		uvlo <= 1'b1;
		settle(10);
		chkl("uvlo", LVL_FAULT, out_level);
		chk1("switch", 1'b0, switch_en);
		@(posedge sys_clk);
		uvlo <= 1'b0;
		settle(10);
		chk1("switch", 1'b1, switch_en);
		$display("test simple done");
	endtask
	// Early trip, overlong on-time, long clamp; each then meets undervoltage
	task automatic t_prot();
		for (int k = 0; k < 3; k++)
		begin
			@(posedge sys_clk);
			switch_on <= (k < 2);
			clamp_active <= (k == 2);
			cyc(k == 0 ? 5 : (k == 1 ? 70 : 30));
			current_trip <= (k == 0);
			settle(10);
			chkl("swerr", LVL_SWERR, out_level);
			chk1("switch", 1'b0, switch_en);
			@(posedge sys_clk);
			uvlo <= 1'b1;
			settle(10);
			chkl("uvlo", LVL_FAULT, out_level);
			@(posedge sys_clk);
			uvlo <= 1'b0;
			settle(10);
			chkl("after", LVL_SWERR, out_level);
			chk1("switch", 1'b0, switch_en);
			@(posedge sys_clk);
			switch_on <= 1'b0;
			clamp_active <= 1'b0;
			current_trip <= 1'b0;
			rst();
			mon.lvl(1'b0, 600);
		end
		$display("test protection done");
	endtask
	initial
	begin
		cyc(8);
		sys_rst <= 1'b0;
		cyc(4);
		t_bus();
		t_serial();
		t_simple();
		t_prot();
		end_of_test();
	end
endmodule
`default_nettype wire
